// ### src/sfp_consts.svh
// Bit positions, select codes and reset values of the fraction and phase programming words.
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH

// Select codes carried in the four lowest bits of every word.
`define SFP_SEL_MSB 3
`define SFP_SEL_LSB 0
`define SFP_SEL_FREQ 4'h0
`define SFP_SEL_MAIN 4'h1
`define SFP_SEL_AUX 4'h2
`define SFP_SEL_PHASE 4'h3

// Frequency word payload, kept whole above the select code.
`define SFP_FREQ_MSB 31
`define SFP_FREQ_LSB 4

// Main fraction word layout.
`define SFP_MAIN_RSV_MSB 31
`define SFP_MAIN_RSV_LSB 28
`define SFP_MAINF_MSB 27
`define SFP_MAINF_LSB 4

// Auxiliary fraction and modulus word layout.
`define SFP_AUXF_MSB 31
`define SFP_AUXF_LSB 18
`define SFP_AUXM_MSB 17
`define SFP_AUXM_LSB 4
`define SFP_AUXM_MIN 14'h0002

// Phase-control word layout.
`define SFP_PH_RSV_BIT 31
`define SFP_LRD_BIT 30
`define SFP_RESYNC_BIT 29
`define SFP_ADJ_BIT 28
`define SFP_STEP_MSB 27
`define SFP_STEP_LSB 4

// Reset values.
`define SFP_FREQ_RST 28'h0000000
`define SFP_MAINF_RST 24'h000000
`define SFP_AUXF_RST 14'h0000
`define SFP_AUXM_RST 14'h0002
`define SFP_STEP_RST 24'h000000
`define SFP_ACC_RST 24'h000000

`endif

// ### src/sfp_pkg.sv
// Types shared by the fraction and phase register bank.
package sfp_pkg;

    // Auxiliary fraction numerator with its modulus.
    typedef struct packed {
        logic [13:0] frac;
        logic [13:0] modulus;
    } sfp_aux_s;

    // Phase-control settings.
    typedef struct packed {
        logic loadResetDisable;
        logic resyncEnable;
        logic adjustEnable;
        logic [23:0] step;
    } sfp_phase_s;

endpackage

// ### src/sfp_regs.sv
// Serial-programmed fraction, auxiliary modulus and phase-control registers.
`timescale 1ns/1ps
`include "sfp_consts.svh"

module sfp_regs (
    input wire logic clk_sys, // System clock, 25 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic sclkLink, // Serial clock from the host.
    input wire logic sdataLink, // Serial data, MSB first.
    input wire logic latchEnLink, // Latch enable; high ends a word.
    output logic [27:0] freqWord, // Committed frequency word payload.
    output logic [23:0] mainFrac, // Committed main fraction numerator.
    output sfp_pkg::sfp_aux_s auxCfg, // Committed auxiliary values.
    output sfp_pkg::sfp_phase_s phaseCtrl, // Phase-control settings.
    output logic [23:0] phaseOffset, // Accumulated phase offset.
    output logic commitPulse, // Frequency word taken.
    output logic modResetPulse, // Modulator reset request.
    output logic resyncReqPulse, // Phase resync request.
    output logic formatErrPulse // Word broke a host-side constraint.
);

    // Link-side shift register, clocked by the host's serial clock.
    logic [31:0] shiftWord_ff;

    // Latch-enable synchroniser and edge detector on the system clock.
    logic leMeta_ff;
    logic leSync_ff;
    logic leDly_ff;
    logic leRise;

    // Captured word and its one-cycle valid flag.
    logic [31:0] wordCap_ff;
    logic capValid_ff;

    // Decoded fields of the captured word.
    logic [3:0] selCode;
    logic wrFreq;
    logic wrMain;
    logic wrAux;
    logic wrPhase;
    logic [3:0] mainRsv;
    logic [23:0] mainField;
    sfp_pkg::sfp_aux_s auxField;
    sfp_pkg::sfp_phase_s phaseField;
    logic phaseRsv;
    logic badMain;
    logic badAux;
    logic badPhase;
    logic badWord;

    // Held register state.
    logic [27:0] freqWord_ff;
    logic [23:0] mainShadow_ff;
    logic [23:0] mainFrac_ff;
    sfp_pkg::sfp_aux_s auxShadow_ff;
    sfp_pkg::sfp_aux_s auxCfg_ff;
    sfp_pkg::sfp_phase_s phaseCtrl_ff;
    logic [23:0] phaseOffset_ff;
    logic [23:0] nxt_phaseOffset;
    logic commitPulse_ff;
    logic modResetPulse_ff;
    logic resyncReqPulse_ff;
    logic formatErrPulse_ff;

    // Bits shift in while the latch enable is low and freeze once it rises.
    // The serial clock may stop between words, so nothing here may rely on
    // an edge after the latch enable rises; the system side takes over.
    always_ff @(posedge sclkLink)
    begin
        if (!latchEnLink)
        begin
            shiftWord_ff <= {shiftWord_ff[30:0], sdataLink};
        end
    end

    // Two flops bring the latch enable into the system domain.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            leMeta_ff <= 1'b0;
            leSync_ff <= 1'b0;
            leDly_ff <= 1'b0;
        end
        else
        begin
            leMeta_ff <= latchEnLink;
            leSync_ff <= leMeta_ff;
            leDly_ff <= leSync_ff;
        end
    end

    // A rising latch enable, seen after synchronisation, marks a whole word.
    assign leRise = leSync_ff & ~leDly_ff;

    // The shift register is stable while the latch enable is high, so the
    // word can be copied across once the synchronised edge is seen.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            capValid_ff <= 1'b0;
            wordCap_ff <= 32'h00000000;
        end
        else
        begin
            capValid_ff <= leRise;
            if (leRise)
            begin
                wordCap_ff <= shiftWord_ff;
            end
        end
    end

    // Select decode on the low four bits of the captured word.
    assign selCode = wordCap_ff[`SFP_SEL_MSB:`SFP_SEL_LSB];
    assign wrFreq = capValid_ff && (selCode == `SFP_SEL_FREQ);
    assign wrMain = capValid_ff && (selCode == `SFP_SEL_MAIN);
    assign wrAux = capValid_ff && (selCode == `SFP_SEL_AUX);
    assign wrPhase = capValid_ff && (selCode == `SFP_SEL_PHASE);

    // Field extraction from the captured word.
    assign mainRsv = wordCap_ff[`SFP_MAIN_RSV_MSB:`SFP_MAIN_RSV_LSB];
    assign mainField = wordCap_ff[`SFP_MAINF_MSB:`SFP_MAINF_LSB];
    assign auxField.frac = wordCap_ff[`SFP_AUXF_MSB:`SFP_AUXF_LSB];
    assign auxField.modulus = wordCap_ff[`SFP_AUXM_MSB:`SFP_AUXM_LSB];
    assign phaseRsv = wordCap_ff[`SFP_PH_RSV_BIT];
    assign phaseField.loadResetDisable = wordCap_ff[`SFP_LRD_BIT];
    assign phaseField.resyncEnable = wordCap_ff[`SFP_RESYNC_BIT];
    assign phaseField.adjustEnable = wordCap_ff[`SFP_ADJ_BIT];
    assign phaseField.step = wordCap_ff[`SFP_STEP_MSB:`SFP_STEP_LSB];

    // Host-side constraints are not enforced, only reported; the word is
    // still stored so that software sees exactly what it wrote.
    assign badMain = wrMain && (mainRsv != 4'h0);
    assign badAux = wrAux && ((auxField.modulus < `SFP_AUXM_MIN)
        || (auxField.frac >= auxField.modulus));
    assign badPhase = wrPhase && (phaseRsv
        || (phaseField.resyncEnable && phaseField.adjustEnable));
    assign badWord = badMain || badAux || badPhase;

    // The 24-bit add drops its carry, which gives the wrap for free.
    assign nxt_phaseOffset = phaseOffset_ff + phaseCtrl_ff.step;

    // Main fraction and auxiliary values land in shadow stages first.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mainShadow_ff <= `SFP_MAINF_RST;
            auxShadow_ff.frac <= `SFP_AUXF_RST;
            auxShadow_ff.modulus <= `SFP_AUXM_RST;
        end
        else
        begin
            if (wrMain)
            begin
                mainShadow_ff <= mainField;
            end
            if (wrAux)
            begin
                auxShadow_ff <= auxField;
            end
        end
    end

    // Phase control takes effect at once; it steers the next commit.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            phaseCtrl_ff.loadResetDisable <= 1'b0;
            phaseCtrl_ff.resyncEnable <= 1'b0;
            phaseCtrl_ff.adjustEnable <= 1'b0;
            phaseCtrl_ff.step <= `SFP_STEP_RST;
        end
        else if (wrPhase)
        begin
            phaseCtrl_ff <= phaseField;
        end
    end

    // A frequency word write moves the shadows into the live registers.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            freqWord_ff <= `SFP_FREQ_RST;
            mainFrac_ff <= `SFP_MAINF_RST;
            auxCfg_ff.frac <= `SFP_AUXF_RST;
            auxCfg_ff.modulus <= `SFP_AUXM_RST;
        end
        else if (wrFreq)
        begin
            freqWord_ff <= wordCap_ff[`SFP_FREQ_MSB:`SFP_FREQ_LSB];
            mainFrac_ff <= mainShadow_ff;
            auxCfg_ff <= auxShadow_ff;
        end
    end

    // Phase accumulator steps only on a frequency word with adjust on.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            phaseOffset_ff <= `SFP_ACC_RST;
        end
        else if (wrFreq && phaseCtrl_ff.adjustEnable)
        begin
            phaseOffset_ff <= nxt_phaseOffset;
        end
    end

    // One-cycle action pulses that follow a frequency word write, and the format-error pulse that follows a bad word.
    // Resync timing against loop settling belongs to the loop logic; this
    // block only raises the request.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            commitPulse_ff <= 1'b0;
            modResetPulse_ff <= 1'b0;
            resyncReqPulse_ff <= 1'b0;
            formatErrPulse_ff <= 1'b0;
        end
        else
        begin
            commitPulse_ff <= wrFreq;
            modResetPulse_ff <= wrFreq && !phaseCtrl_ff.loadResetDisable;
            resyncReqPulse_ff <= wrFreq && phaseCtrl_ff.resyncEnable;
            formatErrPulse_ff <= badWord;
        end
    end

    // Outputs straight from flops.
    assign freqWord = freqWord_ff;
    assign mainFrac = mainFrac_ff;
    assign auxCfg = auxCfg_ff;
    assign phaseCtrl = phaseCtrl_ff;
    assign phaseOffset = phaseOffset_ff;
    assign commitPulse = commitPulse_ff;
    assign modResetPulse = modResetPulse_ff;
    assign resyncReqPulse = resyncReqPulse_ff;
    assign formatErrPulse = formatErrPulse_ff;

    // A synchronised latch edge always yields a captured word.
    a_latch_capture: assert property (
        @(posedge clk_sys) disable iff (rst)
        leRise |=> (capValid_ff && (wordCap_ff == $past(shiftWord_ff))))
        else $error("latched word not captured");

    // Main fraction write lands in the shadow only, live value unchanged.
    a_main_shadow: assert property (
        @(posedge clk_sys) disable iff (rst)
        wrMain |=> ((mainShadow_ff == $past(wordCap_ff[27:4]))
            && $stable(mainFrac_ff)))
        else $error("main fraction write misrouted");

    // Auxiliary write leaves the live auxiliary values alone.
    a_aux_buffered: assert property (
        @(posedge clk_sys) disable iff (rst)
        wrAux |=> ((auxShadow_ff.frac == $past(wordCap_ff[31:18]))
            && (auxShadow_ff.modulus == $past(wordCap_ff[17:4]))
            && $stable(auxCfg_ff)))
        else $error("auxiliary write not buffered");

    // Commit copies both shadows into the live registers.
    a_commit_copy: assert property (
        @(posedge clk_sys) disable iff (rst)
        wrFreq |=> ((auxCfg_ff == $past(auxShadow_ff))
            && (mainFrac_ff == $past(mainShadow_ff)) && commitPulse_ff))
        else $error("commit did not copy shadows");

    // Modulator reset follows a commit exactly when not disabled.
    a_mod_reset: assert property (
        @(posedge clk_sys) disable iff (rst)
        capValid_ff |=> (modResetPulse_ff
            == ($past(wrFreq) && !$past(phaseCtrl_ff.loadResetDisable))))
        else $error("modulator reset wrong");

    // Modulator reset is a single-cycle pulse.
    a_reset_single: assert property (
        @(posedge clk_sys) disable iff (rst)
        modResetPulse_ff |=> !modResetPulse_ff)
        else $error("modulator reset longer than one cycle");

    // Adjust on: each commit advances the offset by the step, mod 2^24.
    a_phase_step: assert property (
        @(posedge clk_sys) disable iff (rst)
        (wrFreq && phaseCtrl_ff.adjustEnable) |=>
            (phaseOffset_ff == 24'($past(phaseOffset_ff) + $past(phaseCtrl_ff.step))))
        else $error("phase offset not stepped");

    // Without a commit under adjust the offset holds.
    a_phase_hold: assert property (
        @(posedge clk_sys) disable iff (rst)
        !(wrFreq && phaseCtrl_ff.adjustEnable) |=> $stable(phaseOffset_ff))
        else $error("phase offset moved without commit");

    // Phase-control write takes its bits from the documented positions.
    a_phase_fields: assert property (
        @(posedge clk_sys) disable iff (rst)
        wrPhase |=> ((phaseCtrl_ff.step == $past(wordCap_ff[27:4]))
            && (phaseCtrl_ff.adjustEnable == $past(wordCap_ff[28]))
            && (phaseCtrl_ff.resyncEnable == $past(wordCap_ff[29]))
            && (phaseCtrl_ff.loadResetDisable == $past(wordCap_ff[30]))))
        else $error("phase-control fields misplaced");

    // Resync request only on a commit with resync enabled.
    a_resync_req: assert property (
        @(posedge clk_sys) disable iff (rst)
        resyncReqPulse_ff |-> ($past(wrFreq) && $past(phaseCtrl_ff.resyncEnable)))
        else $error("spurious resync request");

endmodule

// ### bench/sfp_host.sv
// Host-side model that writes 32-bit words over the three-wire link.
`timescale 1ns/1ps

module sfp_host (
    output logic sclkLink, // Link clock, still between words.
    output logic sdataLink, // Serial data, MSB first.
    output logic latchEnLink // Latch enable, high ends a word.
);
    // The link starts idle with its clock low.
    initial
    begin
        sclkLink = 1'b0;
        sdataLink = 1'b0;
        latchEnLink = 1'b0;
    end

    // Shifts one word at an 80 ns bit time, data changing while the clock is low.
    // After the last bit the data line shows the inverse, so a stale bit cannot pass.
    task automatic writeWord(input logic [31:0] w);
        int i;
        #7;
        for (i = 31; i >= 0; i--)
        begin
            sdataLink = w[i];
            #40 sclkLink = 1'b1;
            #40 sclkLink = 1'b0;
        end
        sdataLink = ~w[0];
        #20 latchEnLink = 1'b1;
        #240 latchEnLink = 1'b0;
        #40;
    endtask
endmodule

// ### bench/sfp_regs_test.sv
// Self-checking bench for the fraction and phase register bank.
`timescale 1ns/1ps
`include "sfp_consts.svh"

module sfp_regs_test;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sclkLink;
    logic sdataLink;
    logic latchEnLink;
    logic [27:0] freqWord;
    logic [23:0] mainFrac;
    sfp_pkg::sfp_aux_s auxCfg;
    sfp_pkg::sfp_phase_s phaseCtrl;
    logic [23:0] phaseOffset;
    logic commitPulse;
    logic modResetPulse;
    logic resyncReqPulse;
    logic formatErrPulse;
    int errors = 0;
    int n_checks = 0;
    int nCom = 0, nMod = 0, nRes = 0, nFmt = 0;
    int eCom = 0, eMod = 0, eRes = 0, eFmt = 0;

    sfp_regs sfp_regs_i (
        .clk_sys(clk_sys), .rst(rst), .sclkLink(sclkLink), .sdataLink(sdataLink),
        .latchEnLink(latchEnLink), .freqWord(freqWord), .mainFrac(mainFrac),
        .auxCfg(auxCfg), .phaseCtrl(phaseCtrl), .phaseOffset(phaseOffset),
        .commitPulse(commitPulse), .modResetPulse(modResetPulse),
        .resyncReqPulse(resyncReqPulse), .formatErrPulse(formatErrPulse)
    );

    sfp_host sfp_host_i (
        .sclkLink(sclkLink), .sdataLink(sdataLink), .latchEnLink(latchEnLink)
    );

    // System clock, 40 ns period.
    always #20 clk_sys = ~clk_sys;

    // Pulses last one cycle, so they are counted at every falling edge rather than polled.
    // The falling edge sits mid-cycle, well clear of the edge that launches a pulse.
    always @(negedge clk_sys)
    begin
        if (commitPulse === 1'b1) nCom++;
        if (modResetPulse === 1'b1) nMod++;
        if (resyncReqPulse === 1'b1) nRes++;
        if (formatErrPulse === 1'b1) nFmt++;
    end

    task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic checkCount(input int got, input int exp);
        n_checks++;
        if (got != exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic checkPulses();
        checkCount(nCom, eCom);
        checkCount(nMod, eMod);
        checkCount(nRes, eRes);
        checkCount(nFmt, eFmt);
    endtask

    // One word, then two cycles so the three-to-four cycle crossing has landed.
    task automatic send(input logic [31:0] w);
        sfp_host_i.writeWord(w);
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic testReset();
        checkVal(32'(freqWord), 32'h0);
        checkVal(32'(mainFrac), 32'h0);
        checkVal(32'(auxCfg), 32'h00000002);
        checkVal(32'(phaseCtrl), 32'h0);
        checkVal(32'(phaseOffset), 32'h0);
    endtask

    task automatic testBuffered();
        send({4'h0, 24'habcdef, `SFP_SEL_MAIN});
        send({14'd5, 14'd100, `SFP_SEL_AUX});
        checkVal(32'(mainFrac), 32'h0);
        checkVal(32'(auxCfg), 32'h00000002);
        send({28'h1234567, `SFP_SEL_FREQ});
        eCom++;
        eMod++;
        checkVal(32'(freqWord), 32'h01234567);
        checkVal(32'(mainFrac), 32'h00abcdef);
        checkVal(32'(auxCfg), 32'({14'd5, 14'd100}));
        checkPulses();
    endtask

    task automatic testAdjust();
        send({1'b0, 1'b1, 1'b0, 1'b1, 24'hc00000, `SFP_SEL_PHASE});
        checkVal(32'(phaseCtrl), 32'({1'b1, 1'b0, 1'b1, 24'hc00000}));
        checkVal(32'(phaseOffset), 32'h0);
        send({14'h3ffe, 14'h3fff, `SFP_SEL_AUX});
        send({28'h0000abc, `SFP_SEL_FREQ});
        eCom++;
        checkVal(32'(phaseOffset), 32'h00c00000);
        checkVal(32'(auxCfg), 32'({14'h3ffe, 14'h3fff}));
        send({28'h0000abc, `SFP_SEL_FREQ});
        eCom++;
        checkVal(32'(phaseOffset), 32'h00800000);
        checkPulses();
    endtask

    task automatic testResync();
        send({14'd0, 14'd2, `SFP_SEL_AUX});
        send({1'b0, 1'b0, 1'b1, 1'b0, 24'h000010, `SFP_SEL_PHASE});
        send({28'h0000def, `SFP_SEL_FREQ});
        eCom++;
        eMod++;
        eRes++;
        checkVal(32'(phaseOffset), 32'h00800000);
        checkPulses();
    endtask

    task automatic testUnknown();
        int s;
        for (s = 4; s < 16; s++)
        begin
            send({28'hfffffff, s[3:0]});
            checkVal(32'(freqWord), 32'h00000def);
            checkVal(32'(phaseCtrl), 32'({1'b0, 1'b1, 1'b0, 24'h000010}));
        end
        checkPulses();
    endtask

    task automatic testFormat();
        logic [31:0] bad [5];
        int i;
        bad[0] = {4'h8, 24'h000001, `SFP_SEL_MAIN};
        bad[1] = {14'd0, 14'd1, `SFP_SEL_AUX};
        bad[2] = {14'd9, 14'd9, `SFP_SEL_AUX};
        bad[3] = {1'b1, 3'b000, 24'h000000, `SFP_SEL_PHASE};
        bad[4] = {1'b0, 1'b0, 1'b1, 1'b1, 24'h000000, `SFP_SEL_PHASE};
        for (i = 0; i < 5; i++)
        begin
            send(bad[i]);
            eFmt++;
        end
        checkVal(32'(phaseCtrl), 32'({1'b0, 1'b1, 1'b1, 24'h000000}));
        checkPulses();
    endtask

    task automatic finish_test();
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // The whole run needs about 80 us; the limit leaves wide margin.
    initial
    begin
        #1000000;
        errors++;
        finish_test();
    end

    // Main sequence: reset for eight cycles, then each scenario in turn.
    initial
    begin
        repeat (8) @(posedge clk_sys);
        #1 rst = 1'b0;
        testReset();
        testBuffered();
        testAdjust();
        testResync();
        testUnknown();
        testFormat();
        finish_test();
    end
endmodule
